/* File: gate_status_fault_indicator.sv */
// gate operator status display, beeper, lamps and fault lockout logic
// Notes on behaviour
// - power-up: dashes, version, then gate type
// - leaving programming reruns the power-up display
// - idle shows rotating dashes, direction shows charging
// - hold last position code up to one minute
// - pre-start countdown in whole seconds
// - nonzero reverse delay counts down on display
// - show elapsed running seconds while moving
// - two obstructions lock out, constant beep
// - reset press clears lockout, never starts motion
// - link failure: blink lamp, code, minute alarm
// - transmitter trouble follows its causes, gate normal
// - trouble doubles beeps, run tail, idle chirps
// - run timeout locks out, then double beeps
// - separate timeout codes, max-run lamp lit
// - emergency full open locks until stop
// - battery fault disables until upper threshold
// - peer entrapment disables until peer clears
// - low supply disables until supply recovers
// - input during lockout: own code, stop clears
// - firmware mismatch and memory failure disable gate
// - motor mismatch retried on next movement request
// - mains loss and post-loss timeout codes
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "gate_status_map.svh"

module gate_status_fault_indicator
	import gate_status_pkg::*;
#(
	parameter int         QTR_CYCLES  = int'((64'd`QTR_MS * 64'd1000000000) / 64'd`CLK_PS),
	parameter logic [7:0] FW_VERSION  = 8'h2A, // arbitrary value
	parameter logic       BATT_MODEL  = 1'b0
) (
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic        stop_button_i,
	input  wire logic        reset_button_i,
	input  wire logic        emergency_open_input_i,
	input  wire logic        peer_entrap_i,
	input  wire logic        low_ac_i,
	input  wire logic        batt_below_fail_i,
	input  wire logic        batt_above_upper_i,
	input  wire logic        mains_lost_i,
	input  wire logic        moving_i,
	input  wire logic        dir_open_i,
	input  wire logic        stopped_i,
	input  wire logic        full_open_i,
	input  wire logic        full_close_i,
	input  wire logic        obstruct_i,
	input  wire logic        prestart_i,
	input  wire logic        reverse_i,
	input  wire logic        move_req_i,
	input  wire logic        prog_exit_i,
	input  wire logic        charging_i,
	input  wire logic        peer_link_fail_i,
	input  wire logic        fw_incompat_i,
	input  wire logic        nvm_fail_i,
	input  wire logic        motor_mismatch_i,
	input  wire logic        motor_fail_i,
	input  wire logic        open_now_mode_i,
	input  wire logic        tx_low_batt_i,
	input  wire logic        tx_tamper_i,
	input  wire logic        tx_missing_i,
	output logic [15:0]      display_o,
	output logic             beeper_o,
	output logic             peer_link_lamp_o,
	output logic             max_run_lamp_o,
	output logic             run_permit_o,
	output logic             emergency_permit_o,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	////////////////////////////////////////////////////////////////////////

	localparam state_t RST_STATE = '{
		phase: PH_DASH,
		ctrl:  `CTRL_RESET,
		default: '0
	};

	state_t      r;
	state_t      n;
	logic [7:0]  pins;
	logic [7:0]  press;
	logic [7:0]  lvl;
	logic [14:0] f;
	logic [3:0]  code;
	logic        q_tick;
	logic        s_tick;
	logic        trouble;
	logic        fast;
	logic        cont;
	logic        move_rise;
	logic        stop_p;
	logic        clr_p;
	logic        idle;
	logic [1:0]  wsel;
	logic [1:0]  rsel;

	// two ascii digits, clamped at 99
	function automatic logic [15:0] dec2(input logic [7:0] v);
		logic [7:0] c;
		c = (v > 8'd99) ? 8'd99 : v;
		return {8'(`CH_ZERO + c / 8'd10), 8'(`CH_ZERO + c % 8'd10)};
	endfunction

	// 0: unmapped, 1: control, 2: status, 3: fault flags
	function automatic logic [1:0] reg_sel(input logic [3:0] a);
		if (a == `REG_CTRL) begin
			return 2'd1;
		end else if (a == `REG_STATUS) begin
			return 2'd2;
		end else if (a == `REG_FAULTS) begin
			return 2'd3;
		end else begin
			return 2'd0;
		end
	endfunction

	assign pins = {mains_lost_i, batt_above_upper_i, batt_below_fail_i, low_ac_i,
		peer_entrap_i, emergency_open_input_i, reset_button_i, stop_button_i};

	// a change counts only once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			assign lvl[gi]   = (r.s2[gi] == r.s3[gi]) ? r.s3[gi] : r.flt[gi];
			assign press[gi] = lvl[gi] & ~r.flt[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////

	assign q_tick    = (r.qcnt == 24'(QTR_CYCLES - 1));
	assign s_tick    = q_tick && (r.qtr == 2'd3);
	assign trouble   = tx_low_batt_i | tx_tamper_i | tx_missing_i;
	assign move_rise = moving_i & ~r.moving_d;
	assign stop_p    = press[`PIN_STOP];
	assign clr_p     = press[`PIN_STOP] | press[`PIN_RESET];

	always_comb begin
		f = r.fl;
		f[`FLT_LINK]   = peer_link_fail_i;
		f[`FLT_PEER]   = r.flt[`PIN_PEER];
		f[`FLT_LOWAC]  = r.flt[`PIN_LOWAC];
		f[`FLT_COMPAT] = fw_incompat_i;
		f[`FLT_NVM]    = nvm_fail_i;
		f[`FLT_MOTOR]  = motor_fail_i;
		f[`FLT_MAINS]  = r.flt[`PIN_MAINS] & open_now_mode_i;
		code = `NO_FAULT;
		for (int i = 14; i >= 0; i--) begin
			if (f[i]) begin
				code = 4'(i);
			end
		end
	end

	assign idle = !moving_i && r.cd == 8'd0 && r.hold_s == 6'd0;

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		n = r;
		n.s1 = pins;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.flt = lvl;
		n.moving_d = moving_i;
		n.lnk_d = peer_link_fail_i;
		n.qcnt = q_tick ? 24'h000000 : r.qcnt + 24'h000001;
		if (q_tick) begin
			n.qtr = r.qtr + 2'd1;
			// a model with a battery spins the other way while charging
			n.spin = (BATT_MODEL && charging_i) ? r.spin - 2'd1 : r.spin + 2'd1;
		end
		if (s_tick) begin
			n.s5 = (r.s5 == `CHIRP_S - 3'd1) ? 3'd0 : r.s5 + 3'd1;
		end

		// power-up display steps
		case (r.phase)
			PH_DASH: begin
				if (s_tick) begin
					n.pstep = r.pstep + 3'd1;
					if (r.pstep == `PWR_STEP_S - 3'd1) begin
						n.pstep = 3'd0;
						n.phase = PH_VER;
					end
				end
			end
			PH_VER: begin
				if (s_tick) begin
					n.pstep = r.pstep + 3'd1;
					if (r.pstep == `PWR_STEP_S - 3'd1) begin
						n.pstep = 3'd0;
						n.phase = PH_TYPE;
					end
				end
			end
			PH_TYPE: begin
				if (s_tick) begin
					n.pstep = r.pstep + 3'd1;
					if (r.pstep == `PWR_STEP_S - 3'd1) begin
						n.pstep = 3'd0;
						n.phase = PH_RUN;
					end
				end
			end
			PH_RUN: begin
				n.pstep = 3'd0;
			end
			default: begin
				n.phase = PH_DASH;
			end
		endcase
		if (prog_exit_i) begin
			n.phase = PH_DASH;
			n.pstep = 3'd0;
		end

		// countdowns
		if (s_tick && r.cd != 8'd0) begin
			n.cd = r.cd - 8'd1;
		end
		if (prestart_i) begin
			n.cd = r.ctrl[`CTRL_PRE];
			n.cd_pre = 1'b1;
		end else if (reverse_i && r.ctrl[`CTRL_REV] != 8'd0) begin
			n.cd = r.ctrl[`CTRL_REV];
			n.cd_pre = 1'b0;
		end

		// run timer
		if (move_rise) begin
			n.run_sec = 8'd0;
			n.hold_s = 6'd0;
		end else if (s_tick && moving_i && r.run_sec != 8'hFF) begin
			n.run_sec = r.run_sec + 8'd1;
		end

		// last position hold
		if (s_tick && r.hold_s != 6'd0) begin
			n.hold_s = r.hold_s - 6'd1;
		end
		if (stopped_i) begin
			n.hold_txt = `TXT_STOP;
			n.hold_s = `HOLD_S;
		end else if (full_close_i) begin
			n.hold_txt = `TXT_CLOSED;
			n.hold_s = `HOLD_S;
		end else if (full_open_i) begin
			n.hold_txt = `TXT_OPEN;
			n.hold_s = `HOLD_S;
		end

		// clears come first so that a set in the same cycle wins
		if (clr_p) begin
			n.fl[`FLT_ENTRAP] = 1'b0;
			n.fl[`FLT_RTO_OPEN] = 1'b0;
			n.fl[`FLT_RTO_CLOSE] = 1'b0;
		end
		if (move_req_i || move_rise) begin
			n.post_rt = 1'b0;
			n.fl[`FLT_MISMATCH] = 1'b0;
		end
		if (clr_p && (r.fl[`FLT_RTO_OPEN] || r.fl[`FLT_RTO_CLOSE])) begin
			n.post_rt = 1'b1;
		end
		if (stop_p) begin
			n.fl[`FLT_EMERG] = 1'b0;
			n.fl[`FLT_INLOCK] = 1'b0;
			n.lnk_alarm = 6'd0;
		end
		if (r.flt[`PIN_BOK]) begin
			n.fl[`FLT_BATT] = 1'b0;
			n.fl[`FLT_RTO_LOSS] = 1'b0;
		end
		if (full_open_i || full_close_i) begin
			n.obst = 1'b0;
		end

		if (obstruct_i) begin
			n.obst = ~r.obst;
			if (r.obst) begin
				n.fl[`FLT_ENTRAP] = 1'b1;
				n.hold_txt = `TXT_ENTRAP;
				n.hold_s = `HOLD_S;
			end
		end
		// the run counter still holds the last run's seconds on the starting edge
		if (moving_i && !move_rise && r.ctrl[`CTRL_MAXRUN] != 8'd0
			&& r.run_sec >= r.ctrl[`CTRL_MAXRUN]
			&& !r.fl[`FLT_RTO_OPEN] && !r.fl[`FLT_RTO_CLOSE]) begin
			n.fl[`FLT_RTO_OPEN] = dir_open_i;
			n.fl[`FLT_RTO_CLOSE] = ~dir_open_i;
			n.fl[`FLT_RTO_LOSS] = r.flt[`PIN_MAINS] | r.fl[`FLT_RTO_LOSS];
			n.post_rt = 1'b0;
		end
		if (r.fl[`FLT_ENTRAP] && (move_req_i || press[`PIN_EMERG])) begin
			n.fl[`FLT_INLOCK] = 1'b1;
		end
		if (full_open_i && r.flt[`PIN_EMERG]) begin
			n.fl[`FLT_EMERG] = 1'b1;
		end
		if (r.flt[`PIN_BFAIL] && r.flt[`PIN_MAINS]) begin
			n.fl[`FLT_BATT] = 1'b1;
		end
		if (motor_mismatch_i) begin
			n.fl[`FLT_MISMATCH] = 1'b1;
		end

		// link alarm runs one minute unless stop silences it
		if (s_tick && r.lnk_alarm != 6'd0 && !stop_p) begin
			n.lnk_alarm = r.lnk_alarm - 6'd1;
		end
		if (peer_link_fail_i && !r.lnk_d) begin
			n.lnk_alarm = `LINK_ALARM_S;
		end

		// run alarm tail after stopping with transmitter trouble
		if (s_tick && r.tail != 9'd0) begin
			n.tail = r.tail - 9'd1;
		end
		if (!trouble) begin
			n.tail = 9'd0;
		end else if (r.moving_d && !moving_i) begin
			n.tail = `RUN_TAIL_S;
		end

		// display
		if (r.phase == PH_DASH) begin
			n.disp = `TXT_DASHES;
		end else if (r.phase == PH_VER) begin
			n.disp = dec2(FW_VERSION);
		end else if (r.phase == PH_TYPE) begin
			n.disp = `TXT_TYPE;
		end else if (code != `NO_FAULT) begin
			// code alternates with its number once a second
			n.disp = r.s5[0] ? dec2({4'h0, code}) : `TXT_ENTRAP;
		end else if (r.cd != 8'd0) begin
			n.disp = dec2(r.cd);
		end else if (moving_i) begin
			n.disp = dec2(r.run_sec);
		end else if (r.hold_s != 6'd0) begin
			n.disp = r.hold_txt;
		end else begin
			case (r.spin)
				2'd0: n.disp = {`CH_DASH, `CH_BLANK};
				2'd1: n.disp = {`CH_BLANK, `CH_DASH};
				2'd2: n.disp = {`CH_BLANK, `CH_LOW};
				default: n.disp = {`CH_LOW, `CH_BLANK};
			endcase
		end

		// beeper
		fast = trouble ? (r.qtr[0] == 1'b0) : (r.qtr == 2'd0);
		cont = f[`FLT_ENTRAP] | f[`FLT_RTO_OPEN] | f[`FLT_RTO_CLOSE] | (r.lnk_alarm != 6'd0);
		if (cont) begin
			n.beep = 1'b1;
		end else if ((r.cd != 8'd0 && r.cd_pre) || moving_i || r.tail != 9'd0) begin
			n.beep = fast;
		end else if (r.post_rt) begin
			n.beep = (r.s5 == 3'd0) && (r.qtr[0] == 1'b0);
		end else if (trouble && idle) begin
			n.beep = (r.s5 == 3'd0) && (r.qtr == 2'd0);
		end else begin
			n.beep = 1'b0;
		end

		// lamps and permits; the reset press only clears, it never asks to run
		n.lnk_lamp = peer_link_fail_i & ~r.qtr[1];
		n.mr_lamp = f[`FLT_RTO_OPEN] | f[`FLT_RTO_CLOSE];
		n.run_ok = (f & `DISABLE_MASK) == 15'h0000 && r.phase == PH_RUN;
		n.emg_ok = (f & `EMERG_MASK) == 15'h0000 && r.phase == PH_RUN;

		// register bus
		wsel = reg_sel(r.awaddr);
		rsel = reg_sel(s_axi_araddr);
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_ok = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_ok = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (r.aw_ok && r.w_ok) begin
			n.aw_ok = 1'b0;
			n.w_ok = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = (wsel == 2'd0) ? 2'b10 : 2'b00;
			if (wsel == 2'd1) begin
				for (int b = 0; b < 3; b++) begin
					if (r.wstrb[b]) begin
						n.ctrl[b*8 +: 8] = r.wdata[b*8 +: 8];
					end
				end
			end
		end else if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			n.rvalid = 1'b1;
			n.rresp = (rsel == 2'd0) ? 2'b10 : 2'b00;
			if (rsel == 2'd1) begin
				n.rdata = {8'h00, r.ctrl};
			end else if (rsel == 2'd2) begin
				n.rdata = {8'h00, r.cd, r.run_sec, trouble, r.beep, r.run_ok,
					code != `NO_FAULT, code};
			end else if (rsel == 2'd3) begin
				n.rdata = {17'h00000, f};
			end else begin
				n.rdata = 32'h00000000;
			end
		end else if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			r <= RST_STATE;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////

	assign s_axi_awready      = !r.aw_ok && !r.bvalid;
	assign s_axi_wready       = !r.w_ok && !r.bvalid;
	assign s_axi_bvalid       = r.bvalid;
	assign s_axi_bresp        = r.bresp;
	assign s_axi_arready      = !r.rvalid;
	assign s_axi_rvalid       = r.rvalid;
	assign s_axi_rdata        = r.rdata;
	assign s_axi_rresp        = r.rresp;
	assign display_o          = r.disp;
	assign beeper_o           = r.beep;
	assign peer_link_lamp_o   = r.lnk_lamp;
	assign max_run_lamp_o     = r.mr_lamp;
	assign run_permit_o       = r.run_ok;
	assign emergency_permit_o = r.emg_ok;

endmodule

/* File: gate_status_map.svh */
// offsets, field positions, reset values and timing counts of the status block
`ifndef GATE_STATUS_MAP_SVH
`define GATE_STATUS_MAP_SVH

`define CLK_PS        25000
`define QTR_MS        250
`define PWR_STEP_S    3'd1
`define HOLD_S        6'd60
`define LINK_ALARM_S  6'd60
`define RUN_TAIL_S    9'd300
`define CHIRP_S       3'd5

`define REG_CTRL      4'h0
`define REG_STATUS    4'h4
`define REG_FAULTS    4'h8
`define CTRL_RESET    24'h3C0203
`define CTRL_PRE      7:0
`define CTRL_REV      15:8
`define CTRL_MAXRUN   23:16

`define PIN_STOP      0
`define PIN_RESET     1
`define PIN_EMERG     2
`define PIN_PEER      3
`define PIN_LOWAC     4
`define PIN_BFAIL     5
`define PIN_BOK       6
`define PIN_MAINS     7

`define FLT_ENTRAP    0
`define FLT_RTO_OPEN  1
`define FLT_RTO_CLOSE 2
`define FLT_LINK      3
`define FLT_EMERG     4
`define FLT_BATT      5
`define FLT_PEER      6
`define FLT_LOWAC     7
`define FLT_INLOCK    8
`define FLT_COMPAT    9
`define FLT_NVM       10
`define FLT_MISMATCH  11
`define FLT_MOTOR     12
`define FLT_MAINS     13
`define FLT_RTO_LOSS  14
`define DISABLE_MASK  15'h1FFF
`define EMERG_MASK    15'h1FF7
`define NO_FAULT      4'hF

`define TXT_DASHES    16'h2D2D
`define TXT_TYPE      16'h534C
`define TXT_STOP      16'h3545
`define TXT_CLOSED    16'h4645
`define TXT_OPEN      16'h4644
`define TXT_ENTRAP    16'h456E
`define CH_DASH       8'h2D
`define CH_LOW        8'h5F
`define CH_BLANK      8'h20
`define CH_ZERO       8'h30

`endif

/* File: gate_status_pkg.sv */
// types of the gate status and fault indication block
package gate_status_pkg;
`include "gate_status_map.svh"

	typedef enum logic [3:0] {
		PH_DASH = 4'b0001,
		PH_VER  = 4'b0010,
		PH_TYPE = 4'b0100,
		PH_RUN  = 4'b1000
	} phase_t;

	typedef struct packed {
		logic [23:0] qcnt;
		logic [1:0]  qtr;
		logic [2:0]  s5;
		phase_t      phase;
		logic [2:0]  pstep;
		logic [7:0]  s1;
		logic [7:0]  s2;
		logic [7:0]  s3;
		logic [7:0]  flt;
		logic [7:0]  cd;
		logic        cd_pre;
		logic [7:0]  run_sec;
		logic        moving_d;
		logic [15:0] hold_txt;
		logic [5:0]  hold_s;
		logic        obst;
		logic [14:0] fl;
		logic [5:0]  lnk_alarm;
		logic        lnk_d;
		logic        post_rt;
		logic [8:0]  tail;
		logic [1:0]  spin;
		logic [15:0] disp;
		logic        beep;
		logic        run_ok;
		logic        emg_ok;
		logic        lnk_lamp;
		logic        mr_lamp;
		logic [23:0] ctrl;
		logic        aw_ok;
		logic        w_ok;
		logic [3:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} state_t;

endpackage

/* File: gate_status_fault_indicator_assertions.sv */
// concurrent checks on the ports of the gate status and fault block
`timescale 1ns/1ps

module gate_status_checker (
	input wire logic        clock_i,
	input wire logic        reset_i,
	input wire logic        prog_exit_i,
	input wire logic [15:0] display_o,
	input wire logic        beeper_o,
	input wire logic        peer_link_lamp_o,
	input wire logic        max_run_lamp_o,
	input wire logic        run_permit_o,
	input wire logic        emergency_permit_o,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rready
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_answer;
		!s_axi_awready ##1 s_axi_bvalid;
	endsequence

	permit_subset_a: assert property (run_permit_o |-> emergency_permit_o)
		else $error("run permit without emergency permit");
	lamp_blocks_a: assert property (max_run_lamp_o |-> ##[0:2] !run_permit_o)
		else $error("max run lamp lit while gate permitted");
	link_blocks_a: assert property (peer_link_lamp_o |-> ##[0:2] !run_permit_o)
		else $error("link lamp lit while gate permitted");
	restart_dash_a: assert property (prog_exit_i |-> ##[1:3] (display_o == 16'h2D2D && !run_permit_o))
		else $error("programming exit did not restart display");
	timeout_beep_a: assert property ($rose(max_run_lamp_o) |-> ##[0:2] beeper_o [*4])
		else $error("run timeout without continuous alarm");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while data pending");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	write_answer_a: assert property (wr_both |=> wr_answer)
		else $error("write response not two cycles after accept");
endmodule

bind gate_status_fault_indicator gate_status_checker i_gate_status_checker (
	.clock_i, .reset_i, .prog_exit_i, .display_o, .beeper_o, .peer_link_lamp_o, .max_run_lamp_o,
	.run_permit_o, .emergency_permit_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rdata, .s_axi_rready
);

/* File: gate_panel_model.sv */
// operator panel buttons and paired peer controller facing the status block
`timescale 1ns/1ps

module gate_panel_model (
	input  wire logic clock_i,
	output logic      stop_o,
	output logic      reset_o,
	output logic      peer_entrap_o,
	output logic      link_fail_o
);
	initial begin
		stop_o = 1'h0;
		reset_o = 1'h0;
		peer_entrap_o = 1'h0;
		link_fail_o = 1'h0;
	end

	// held well past the input filter so a press is never lost
	task automatic press(input bit stop);
		@(posedge clock_i);
		if (stop) stop_o <= 1'h1;
		else reset_o <= 1'h1;
		repeat (8) @(posedge clock_i);
		stop_o <= 1'h0;
		reset_o <= 1'h0;
		repeat (8) @(posedge clock_i);
	endtask

	task automatic peer(input logic entrap, input logic link);
		@(posedge clock_i);
		peer_entrap_o <= entrap;
		link_fail_o <= link;
	endtask
endmodule

/* File: testbench.sv */
// self-checking bench of the gate status and fault indication block
`timescale 1ns/1ps

module testbench;
	import gate_status_pkg::*;
	logic clock_i = 1'h0;
	logic reset_i = 1'h1;
	logic [14:0] lv = 15'h0;
	logic [8:0] pul = 9'h0;
	wire logic stop_w, rst_w, pent_w, plink_w;
	logic [15:0] display_o;
	logic beeper_o, peer_link_lamp_o, max_run_lamp_o, run_permit_o, emergency_permit_o;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int failures = 0;
	int total_checks = 0;
	int seed = 17;

	always #12.5 clock_i = ~clock_i;

	gate_status_fault_indicator #(.QTR_CYCLES(4), .BATT_MODEL(1'b1)) i_gate_status_fault_indicator (
		.clock_i, .reset_i, .stop_button_i(stop_w), .reset_button_i(rst_w),
		.emergency_open_input_i(lv[0]), .peer_entrap_i(pent_w), .low_ac_i(lv[1]),
		.batt_below_fail_i(lv[2]), .batt_above_upper_i(lv[3]), .mains_lost_i(lv[4]),
		.moving_i(lv[5]), .dir_open_i(lv[6]), .stopped_i(pul[0]), .full_open_i(pul[1]),
		.full_close_i(pul[2]), .obstruct_i(pul[3]), .prestart_i(pul[4]), .reverse_i(pul[5]),
		.move_req_i(pul[6]), .prog_exit_i(pul[7]), .charging_i(lv[7]),
		.peer_link_fail_i(plink_w), .fw_incompat_i(lv[8]), .nvm_fail_i(lv[9]),
		.motor_mismatch_i(pul[8]), .motor_fail_i(lv[10]), .open_now_mode_i(lv[11]),
		.tx_low_batt_i(lv[12]), .tx_tamper_i(lv[13]), .tx_missing_i(lv[14]),
		.display_o, .beeper_o, .peer_link_lamp_o, .max_run_lamp_o, .run_permit_o,
		.emergency_permit_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);

	gate_panel_model i_gate_panel_model (
		.clock_i, .stop_o(stop_w), .reset_o(rst_w), .peer_entrap_o(pent_w),
		.link_fail_o(plink_w)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (failures == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	function automatic logic [15:0] dig(input int n);
		return {8'(48 + n / 10), 8'(48 + n % 10)};
	endfunction

	task automatic pulse(input int b);
		@(posedge clock_i);
		pul[b] <= 1'h1;
		@(posedge clock_i);
		pul[b] <= 1'h0;
	endtask

	task automatic setl(input int b, input logic v);
		@(posedge clock_i);
		lv[b] <= v;
	endtask

	// waits bounded; 0 display, 1 permit, 2 beeper, 3 max run lamp, 4 link lamp
	task automatic wait_for(input int s, input logic [15:0] v);
		logic [15:0] g;
		for (int n = 0; n < 600; n++) begin
			@(posedge clock_i);
			g = s == 0 ? display_o : s == 1 ? 16'(run_permit_o) : s == 2 ? 16'(beeper_o)
				: s == 3 ? 16'(max_run_lamp_o) : 16'(peer_link_lamp_o);
			if (g === v) break;
		end
		chk(32'(g), 32'(v));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clock_i);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 100);
		if (!s_axi_bvalid) failures++;
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	// rready stands with the request; data is taken at the edge rvalid is seen
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clock_i);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 100);
		if (!s_axi_rvalid) failures++;
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (30000) @(posedge clock_i);
		failures++;
		end_sim;
	end

	initial begin
		logic [15:0] pwr_q[$] = '{16'h2D2D, 16'h3432, 16'h534C};
		logic [15:0] hold[3] = '{16'h3545, 16'h4644, 16'h4645};
		int fb[4] = '{1, 8, 9, 10};
		int fc[4] = '{7, 9, 10, 12};
		logic [31:0] d;
		logic [1:0] r;
		int pre;
		pre = 2 + ($unsigned($random(seed)) % 5);
		repeat (4) @(posedge clock_i);
		reset_i <= 1'h0;
		for (int k = 0; k < 2; k++) begin
			if (k == 1) pulse(7);
			foreach (pwr_q[i]) wait_for(0, pwr_q[i]);
			wait_for(1, 16'h1);
		end
		setl(7, 1'h1);
		wait_for(0, 16'h202D);
		while (display_o == 16'h202D) @(posedge clock_i);
		chk(32'(display_o), 32'h2D20);
		rd(4'h0, d, r);
		chk(d, 32'h003C0203);
		rd(4'hC, d, r);
		chk(32'(r), 32'h2);
		wr(4'hC, 32'h0, r);
		chk(32'(r), 32'h2);
		foreach (hold[p]) begin
			pulse(p);
			wait_for(0, hold[p]);
		end
		s_axi_wstrb <= 4'h6;
		wr(4'h0, {8'hFF, 8'h03, 8'h02, 8'h77}, r);
		rd(4'h0, d, r);
		chk(d, 32'h00030203);
		s_axi_wstrb <= 4'hF;
		wr(4'h0, {8'h0, 8'h03, 8'h02, 8'(pre)}, r);
		pulse(4);
		wait_for(0, dig(pre));
		wait_for(0, dig(pre - 1));
		pulse(5);
		wait_for(0, dig(2));
		wait_for(0, dig(1));
		for (int dir = 1; dir >= 0; dir--) begin
			setl(6, 1'(dir));
			setl(5, 1'h1);
			wait_for(0, dig(1));
			wait_for(3, 16'h1);
			wait_for(2, 16'h1);
			setl(5, 1'h0);
			rd(4'h8, d, r);
			chk({29'h0, d[2:0]}, dir ? 32'h2 : 32'h4);
			i_gate_panel_model.press(1'h0);
			wait_for(3, 16'h0);
			wait_for(1, 16'h1);
		end
		pulse(3);
		pulse(3);
		wait_for(2, 16'h1);
		wait_for(0, 16'h456E);
		wait_for(1, 16'h0);
		i_gate_panel_model.press(1'h0);
		wait_for(1, 16'h1);
		setl(0, 1'h1);
		repeat (8) @(posedge clock_i);
		pulse(1);
		wait_for(1, 16'h0);
		setl(0, 1'h0);
		i_gate_panel_model.press(1'h0);
		rd(4'h8, d, r);
		chk({31'h0, d[4]}, 32'h1);
		i_gate_panel_model.press(1'h1);
		wait_for(1, 16'h1);
		foreach (fb[i]) begin
			setl(fb[i], 1'h1);
			wait_for(1, 16'h0);
			rd(4'h8, d, r);
			chk({17'h0, d[14:0]}, 32'h1 << fc[i]);
			rd(4'h4, d, r);
			chk({28'h0, d[3:0]}, 32'(fc[i]));
			setl(fb[i], 1'h0);
			wait_for(1, 16'h1);
		end
		pulse(8);
		wait_for(1, 16'h0);
		pulse(6);
		wait_for(1, 16'h1);
		setl(11, 1'h1);
		setl(4, 1'h1);
		repeat (8) @(posedge clock_i);
		rd(4'h4, d, r);
		chk({28'h0, d[3:0]}, 32'hD);
		chk(32'(run_permit_o), 32'h1);
		setl(11, 1'h0);
		setl(2, 1'h1);
		wait_for(1, 16'h0);
		setl(2, 1'h0);
		repeat (8) @(posedge clock_i);
		chk(32'(run_permit_o), 32'h0);
		setl(3, 1'h1);
		wait_for(1, 16'h1);
		lv[4:2] <= 3'h0;
		i_gate_panel_model.peer(1'h1, 1'h0);
		wait_for(1, 16'h0);
		i_gate_panel_model.peer(1'h0, 1'h0);
		wait_for(1, 16'h1);
		i_gate_panel_model.peer(1'h0, 1'h1);
		wait_for(4, 16'h1);
		wait_for(4, 16'h0);
		chk(32'(emergency_permit_o), 32'h1);
		i_gate_panel_model.peer(1'h0, 1'h0);
		i_gate_panel_model.press(1'h1);
		wait_for(1, 16'h1);
		for (int b = 12; b < 15; b++) begin
			setl(b, 1'h1);
			repeat (8) @(posedge clock_i);
			rd(4'h4, d, r);
			chk({30'h0, d[7], d[5]}, 32'h3);
			setl(b, 1'h0);
			repeat (8) @(posedge clock_i);
			rd(4'h4, d, r);
			chk({31'h0, d[7]}, 32'h0);
		end
		end_sim;
	end
endmodule
